/* core/tpcm_timer.sv */
// 16-bit timer: single and dual pwm, input capture, ahb-lite registers
// Overview of operation
// - pwm and capture count from the prescaled clock, not the pin.
// - single pwm: output toggles at count equal to pwm match value.
// - pwm: at reload raise interrupt, count restarts at 0001H.
// - polarity 1: start high, low at match, high again at reload.
// - polarity 0: start low, high at match, low again at reload.
// - written start count affects first pass only; later passes 0001H.
// - dual pwm drives waveform and its complement on two pins.
// - dual pwm delays every rising edge by 0 to 128 clocks.
// - dual pwm needs extended mode bit plus primary mode field.
// - dual pwm turns the input pin into the complement output.
// - capture copies count into pwm value on selected edge.
// - capture raises interrupt, sets cause flag, counter continues.
// - capture mode reload raises interrupt, clears flag, keeps counting.
// - capture interrupt on both events unless source field restricts.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module tpcm_timer #(
  parameter int DEAD_W = 8
) (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // timer pins
  input wire logic tin_i,
  output logic tout_o,
  output logic tin_o,
  output logic tin_oe,
  // interrupt request pulse
  output logic timer_irq
);
  logic en_q, pol_q, ext_q, cap_flag_q;
  logic [2:0] pre_q, modef_q;
  logic [1:0] src_q;
  logic [15:0] cnt_q, reload_q, pwm_val_q;
  logic [7:0] dead_q;
  tpcm_pkg::tpcm_mode_t mode_q;
  logic [6:0] presc_q;
  logic tin_prev_q, pwm_q, irq_q, tout_q, comp_q, oe_q;
  logic ap_wr_q, hready_q, hresp_q;
  logic [7:0] ap_addr_q;
  logic [31:0] rdata_q, rd_mux;
  logic db_main, db_comp;

  function automatic logic [6:0] pre_mask(input logic [2:0] e);
    pre_mask = ~(7'h7F << e);
  endfunction

  // bus decode; only whole-word transfers are expected, hsize is not used
  wire ap_take = hsel & hready & htrans[1];
  wire wr_ctrl = ap_wr_q && ap_addr_q == tpcm_pkg::OFS_CTRL;
  wire wr_ctrl2 = ap_wr_q && ap_addr_q == tpcm_pkg::OFS_CTRL2;
  wire wr_count = ap_wr_q && ap_addr_q == tpcm_pkg::OFS_COUNT;
  wire wr_reload = ap_wr_q && ap_addr_q == tpcm_pkg::OFS_RELOAD;
  wire wr_pwm = ap_wr_q && ap_addr_q == tpcm_pkg::OFS_PWM;
  wire wr_dead = ap_wr_q && ap_addr_q == tpcm_pkg::OFS_DEAD;

  // timer events
  wire pwm_mode = mode_q == tpcm_pkg::TPCM_PWM1 ||
                  mode_q == tpcm_pkg::TPCM_PWM2;
  wire cap_mode = mode_q == tpcm_pkg::TPCM_CAP;
  wire dual = mode_q == tpcm_pkg::TPCM_PWM2;
  wire tick = en_q && (pwm_mode || cap_mode) &&
              presc_q == pre_mask(pre_q);
  wire reload_hit = tick && !wr_count && cnt_q == reload_q;
  wire match_hit = tick && !wr_count && pwm_mode && cnt_q == pwm_val_q;
  wire cap_edge = en_q && cap_mode &&
                  (pol_q ? (tin_i & ~tin_prev_q)
                         : (~tin_i & tin_prev_q));

  always_comb begin
    case (haddr[7:0])
      tpcm_pkg::OFS_CTRL: rd_mux = {24'h000000, modef_q, pre_q, pol_q, en_q};
      tpcm_pkg::OFS_CTRL2: rd_mux = {28'h0000000, cap_flag_q, src_q, ext_q};
      tpcm_pkg::OFS_COUNT: rd_mux = {16'h0000, cnt_q};
      tpcm_pkg::OFS_RELOAD: rd_mux = {16'h0000, reload_q};
      tpcm_pkg::OFS_PWM: rd_mux = {16'h0000, pwm_val_q};
      tpcm_pkg::OFS_DEAD: rd_mux = {24'h000000, dead_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // zero-wait slave: read data is sampled in the address phase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else if (clk_en) begin
      ap_wr_q <= ap_take & hwrite;
      ap_addr_q <= haddr[7:0];
      rdata_q <= (ap_take & ~hwrite) ? rd_mux : 32'h00000000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      pol_q <= 1'b0;
      pre_q <= 3'h0;
      modef_q <= 3'h0;
      ext_q <= 1'b0;
      src_q <= 2'h0;
      reload_q <= tpcm_pkg::RELOAD_RST;
      dead_q <= tpcm_pkg::DEAD_RST;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        en_q <= hwdata[tpcm_pkg::CTRL_EN_BIT];
        pol_q <= hwdata[tpcm_pkg::CTRL_POL_BIT];
        pre_q <= hwdata[tpcm_pkg::CTRL_PRE_LSB +: 3];
        modef_q <= hwdata[tpcm_pkg::CTRL_MODE_LSB +: 3];
      end
      if (wr_ctrl2) begin
        ext_q <= hwdata[tpcm_pkg::CTRL2_EXT_BIT];
        src_q <= hwdata[tpcm_pkg::CTRL2_SRC_LSB +: 2];
      end
      if (wr_reload) begin
        reload_q <= hwdata[15:0];
      end
      if (wr_dead) begin
        dead_q <= (hwdata[7:0] > tpcm_pkg::DEAD_MAX) ? tpcm_pkg::DEAD_MAX
                                                     : hwdata[7:0];
      end
    end
  end

  // mode decode from the extended bit and the primary field together
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= tpcm_pkg::TPCM_OFF;
    end else if (clk_en) begin
      case ({ext_q, modef_q})
        {1'b0, tpcm_pkg::MODE_PWM}: mode_q <= tpcm_pkg::TPCM_PWM1;
        {1'b1, tpcm_pkg::MODE_PWM}: mode_q <= tpcm_pkg::TPCM_PWM2;
        {1'b0, tpcm_pkg::MODE_CAPTURE}: mode_q <= tpcm_pkg::TPCM_CAP;
        default: mode_q <= tpcm_pkg::TPCM_OFF;
      endcase
    end
  end

  // prescaler restarts whenever the timer is stopped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= 7'h00;
    end else if (clk_en) begin
      // also held until the mode decode catches up with the enable,
      // otherwise the count runs past the wrap value and stalls a pass
      if (!en_q || !(pwm_mode || cap_mode) || tick) begin
        presc_q <= 7'h00;
      end else begin
        presc_q <= presc_q + 7'h01;
      end
    end
  end

  // counter: software write wins, capture mode counts through reload
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= tpcm_pkg::COUNT_RST;
    end else if (clk_en) begin
      if (wr_count) begin
        cnt_q <= hwdata[15:0];
      end else if (reload_hit && pwm_mode) begin
        cnt_q <= tpcm_pkg::COUNT_RESTART;
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // pwm level; held at polarity when idle so the first pass starts there
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_q <= 1'b0;
    end else if (clk_en) begin
      if (!en_q || !pwm_mode) begin
        pwm_q <= pol_q;
      end else if (reload_hit) begin
        pwm_q <= pol_q;
      end else if (match_hit) begin
        pwm_q <= ~pwm_q;
      end
    end
  end

  // capture value; a capture beats a software write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_val_q <= tpcm_pkg::PWM_RST;
    end else if (clk_en) begin
      if (cap_edge) begin
        pwm_val_q <= cnt_q;
      end else if (wr_pwm) begin
        pwm_val_q <= hwdata[15:0];
      end
    end
  end

  // cause flag: a capture beats a reload clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cap_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (cap_edge) begin
        cap_flag_q <= 1'b1;
      end else if (reload_hit && cap_mode) begin
        cap_flag_q <= 1'b0;
      end
    end
  end

  // interrupt pulse and input edge history
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
      tin_prev_q <= 1'b0;
    end else if (clk_en) begin
      tin_prev_q <= tin_i;
      if (cap_mode) begin
        irq_q <= (cap_edge && src_q != tpcm_pkg::SRC_RELOAD) ||
                 (reload_hit && src_q != tpcm_pkg::SRC_CAPTURE);
      end else begin
        irq_q <= reload_hit && pwm_mode;
      end
    end
  end

  tpcm_deadband #(.DEAD_W(DEAD_W)) u_db_main (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .level_i(pwm_q),
    .delay_i(dead_q),
    .level_o(db_main)
  );

  tpcm_deadband #(.DEAD_W(DEAD_W)) u_db_comp (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .level_i(~pwm_q),
    .delay_i(dead_q),
    .level_o(db_comp)
  );

  // pin stage; costs one cycle but keeps every pin on a flop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tout_q <= 1'b0;
      comp_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (clk_en) begin
      tout_q <= dual ? db_main : pwm_q;
      comp_q <= dual & db_comp;
      oe_q <= dual;
    end
  end

  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign hrdata = rdata_q;
  assign tout_o = tout_q;
  assign tin_o = comp_q;
  assign tin_oe = oe_q;
  assign timer_irq = irq_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_pwm_reload;
    clk_en && pwm_mode && reload_hit;
  endsequence
  sequence s_capture;
    clk_en && cap_edge;
  endsequence

  pwm_reload_a: assert property (
      s_pwm_reload |=> cnt_q == tpcm_pkg::COUNT_RESTART && timer_irq)
    else $error("pwm reload did not restart count with interrupt");
  reload_level_a: assert property (
      s_pwm_reload |=> pwm_q == $past(pol_q))
    else $error("pwm level not restored at reload");
  match_toggle_a: assert property (
      clk_en && match_hit && !reload_hit |=> pwm_q != $past(pwm_q))
    else $error("pwm output did not toggle at match");
  idle_level_a: assert property (
      clk_en && !en_q |=> pwm_q == $past(pol_q))
    else $error("idle output not at polarity level");
  count_hold_a: assert property (
      clk_en && !en_q && !wr_count |=> $stable(cnt_q))
    else $error("counter moved while disabled");
  capture_copy_a: assert property (
      s_capture |=> pwm_val_q == $past(cnt_q) && cap_flag_q)
    else $error("capture did not store count and flag");
  cap_reload_a: assert property (
      clk_en && cap_mode && reload_hit && !cap_edge
      |=> !cap_flag_q && cnt_q == $past(cnt_q) + 16'h0001)
    else $error("capture reload did not clear flag and continue");
  irq_source_a: assert property (
      s_capture and (!reload_hit && src_q == tpcm_pkg::SRC_RELOAD)
      |=> !timer_irq)
    else $error("capture interrupt not masked by source field");
  comp_pin_a: assert property (
      clk_en && dual |=> tin_oe ##1 (tin_oe || !dual))
    else $error("complement pin not driven in dual mode");
  pin_follow_a: assert property (
      clk_en && !dual |=> tout_o == $past(pwm_q) && !tin_o)
    else $error("single pwm pin does not follow the waveform");
endmodule

/* core/tpcm_pkg.sv */
// constants shared by the timer pwm/capture block
package tpcm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0C;
  localparam logic [7:0] OFS_PWM = 8'h10;
  localparam logic [7:0] OFS_DEAD = 8'h14;
  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_PRE_LSB = 2;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL2_EXT_BIT = 0;
  localparam int CTRL2_SRC_LSB = 1;
  localparam int CTRL2_CAP_BIT = 3;
  // mode field and interrupt source encodings
  localparam logic [2:0] MODE_PWM = 3'h3;
  localparam logic [2:0] MODE_CAPTURE = 3'h4;
  localparam logic [1:0] SRC_CAPTURE = 2'h1;
  localparam logic [1:0] SRC_RELOAD = 2'h2;
  // reset and restart values
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] PWM_RST = 16'h0000;
  localparam logic [7:0] DEAD_RST = 8'h00;
  localparam logic [7:0] DEAD_MAX = 8'h80;
  // decoded operating mode
  typedef enum logic [3:0] {
    TPCM_OFF = 4'b0001,
    TPCM_PWM1 = 4'b0010,
    TPCM_PWM2 = 4'b0100,
    TPCM_CAP = 4'b1000
  } tpcm_mode_t;
endpackage

/* core/tpcm_deadband.sv */
// deadband delay on the rising edge of one output
`timescale 1ns/100ps
module tpcm_deadband #(
  parameter int DEAD_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // level in, delay, delayed level out
  input wire logic level_i,
  input wire logic [DEAD_W-1:0] delay_i,
  output logic level_o
);
  logic [DEAD_W-1:0] wait_q;
  logic out_q;
  logic [DEAD_W:0] hi_q;

  // falls at once, rises only after the delay has run out
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= '0;
      out_q <= 1'b0;
    end else if (clk_en) begin
      if (!level_i) begin
        out_q <= 1'b0;
        wait_q <= '0;
      end else if (!out_q) begin
        if (wait_q >= delay_i) begin
          out_q <= 1'b1;
        end else begin
          wait_q <= wait_q + 1'b1;
        end
      end
    end
  end
  assign level_o = out_q;

  // helper: consecutive high cycles of the input
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hi_q <= '0;
    end else if (clk_en) begin
      if (!level_i) begin
        hi_q <= '0;
      end else if (hi_q != '1) begin
        hi_q <= hi_q + 1'b1;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  dead_rise_a: assert property (
      $rose(out_q) |-> hi_q > {1'b0, delay_i})
    else $error("output rose before the deadband elapsed");
  dead_fall_a: assert property (
      clk_en && !level_i |=> !out_q)
    else $error("output did not fall with its input");
endmodule

/* tb/tpcm_pin_model.sv */
// gpio pin model: edge train on the timer input pin
`timescale 1ns/100ps
module tpcm_pin_model (
  // clock and trigger
  input wire logic clk_sys,
  input wire logic go,
  // pin as seen by the timer
  input wire logic tin_o,
  input wire logic tin_oe,
  output logic tin_i
);
  logic drv_q;
  int t_q;
  initial begin
    drv_q = 1'b0;
    t_q = 0;
  end
  // rises at 10 and 24 after go, falls 2 later; edges 14 clocks apart
  always @(posedge clk_sys) begin
    t_q <= go ? 1 : (t_q != 0 ? t_q + 1 : 0);
    drv_q <= (t_q >= 10 && t_q < 12) || (t_q >= 24 && t_q < 26);
  end
  // dual pwm takes the pin over; the train must not fight it
  assign tin_i = tin_oe ? tin_o : drv_q;
endmodule

/* tb/tb_top.sv */
// self-checking bench for the timer pwm/capture block
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] A_CTL = tpcm_pkg::OFS_CTRL;
  localparam logic [7:0] A_CT2 = tpcm_pkg::OFS_CTRL2;
  localparam logic [7:0] A_CNT = tpcm_pkg::OFS_COUNT;
  localparam logic [7:0] A_RLD = tpcm_pkg::OFS_RELOAD;
  localparam logic [7:0] A_PWM = tpcm_pkg::OFS_PWM;
  localparam logic [7:0] A_DB = tpcm_pkg::OFS_DEAD;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } tpcm_row_t;
  typedef struct packed {
    logic pol;
    logic [2:0] pre;
    logic ext;
    logic [7:0] dead;
  } tpcm_pwm_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic hready, hresp, tin_i, tout_o, tin_o, tin_oe, timer_irq;
  logic [31:0] hrdata, rd, p1, ctl;
  int errors = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  int hi_o, hi_c, ovl, n0, k, t, eo, ec;
  // unmapped 0x18, clamp above 128, read-only flag, upper bits dropped
  tpcm_row_t rows [11] = '{
    '{A_CTL, 1'b0, 32'h0, 32'h0},
    '{A_CT2, 1'b0, 32'h0, 32'h0},
    '{A_CNT, 1'b0, 32'h0, {16'h0, tpcm_pkg::COUNT_RST}},
    '{A_RLD, 1'b0, 32'h0, {16'h0, tpcm_pkg::RELOAD_RST}},
    '{A_PWM, 1'b0, 32'h0, {16'h0, tpcm_pkg::PWM_RST}},
    '{A_DB, 1'b0, 32'h0, {24'h0, tpcm_pkg::DEAD_RST}},
    '{8'h18, 1'b1, 32'h5A5A, 32'h0},
    '{A_DB, 1'b1, 32'hFF, {24'h0, tpcm_pkg::DEAD_MAX}},
    '{A_CT2, 1'b1, 32'h8, 32'h0},
    '{A_CNT, 1'b1, 32'h1234, 32'h1234},
    '{A_RLD, 1'b1, 32'hABCD1234, 32'h1234}
  };
  tpcm_pwm_t pwm [6] = '{
    '{1'b0, 3'h0, 1'b0, 8'h00}, '{1'b1, 3'h0, 1'b0, 8'h00},
    '{1'b0, 3'h2, 1'b0, 8'h00}, '{1'b0, 3'h0, 1'b1, 8'h01},
    '{1'b1, 3'h1, 1'b1, 8'h03}, '{1'b0, 3'h7, 1'b1, 8'h80}
  };
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) irq_cnt <= irq_cnt + (timer_irq === 1'b1);
  tpcm_timer u_tpcm_timer (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .tin_i(tin_i),
    .tout_o(tout_o), .tin_o(tin_o), .tin_oe(tin_oe),
    .timer_irq(timer_irq));
  tpcm_pin_model u_tpcm_pin_model (.clk_sys(clk_sys), .go(go),
    .tin_o(tin_o), .tin_oe(tin_oe), .tin_i(tin_i));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for ready or for the next interrupt pulse
  task automatic gap(input logic irq, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((irq ? timer_irq : hready) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    gap(1'b0, n);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    gap(1'b0, n);
    rd = hrdata;
    chk(hresp, 0);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].w)
        bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 32'h0);
      chk(rd, rows[i].e);
    end
    // period 6, match 2; deadband kept inside both phases
    foreach (pwm[i]) begin
      bus(A_CTL, 1'b1, 32'h0);
      bus(A_CT2, 1'b1, {31'h0, pwm[i].ext});
      bus(A_CNT, 1'b1, 32'h1);
      bus(A_PWM, 1'b1, 32'h2);
      bus(A_RLD, 1'b1, 32'h6);
      bus(A_DB, 1'b1, {24'h0, pwm[i].dead});
      ctl = {24'h0, tpcm_pkg::MODE_PWM, pwm[i].pre, pwm[i].pol, 1'b0};
      bus(A_CTL, 1'b1, ctl);
      repeat (pwm[i].dead + 4) @(posedge clk_sys);
      chk(tout_o, pwm[i].pol);
      bus(A_CTL, 1'b1, ctl | 32'h1);
      gap(1'b1, k);
      gap(1'b1, k);
      t = 6 << pwm[i].pre;
      eo = (pwm[i].pol ? 2 : 4) << pwm[i].pre;
      ec = pwm[i].ext ? t - eo - pwm[i].dead : 0;
      eo = eo - (pwm[i].ext ? pwm[i].dead : 0);
      n0 = irq_cnt;
      hi_o = 0;
      hi_c = 0;
      ovl = 0;
      repeat (2 * t) begin
        @(posedge clk_sys);
        hi_o += tout_o;
        hi_c += tin_o;
        ovl += tout_o & tin_o;
      end
      chk(hi_o, 2 * eo);
      chk(hi_c, 2 * ec);
      chk(ovl, 0);
      chk(irq_cnt - n0, 2);
      chk(tin_oe, pwm[i].ext);
    end
    // written start count shortens only the first pass
    bus(A_CTL, 1'b1, 32'h0);
    bus(A_CT2, 1'b1, 32'h0);
    bus(A_CNT, 1'b1, 32'h5);
    bus(A_CTL, 1'b1, {24'h0, tpcm_pkg::MODE_PWM, 5'h01});
    gap(1'b1, k);
    chk(k < 6, 1);
    gap(1'b1, k);
    chk(k, 6);
    // frozen clock enable: no tick, no pulse, pins hold
    clk_en <= 1'b0;
    @(posedge clk_sys);
    n0 = irq_cnt;
    eo = tout_o;
    repeat (20) @(posedge clk_sys);
    chk(irq_cnt - n0, 0);
    chk(tout_o, eo);
    clk_en <= 1'b1;
    gap(1'b1, k);
    chk(k, 6);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({tout_o, tin_oe, timer_irq}, 0);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    bus(A_CNT, 1'b0, 32'h0);
    chk(rd, {16'h0, tpcm_pkg::COUNT_RST});
    // capture on both edge choices, each interrupt source setting
    for (int s = 0; s < 4; s++) begin
      bus(A_CTL, 1'b1, 32'h0);
      bus(A_CT2, 1'b1, s << 1);
      bus(A_CNT, 1'b1, 32'h1);
      bus(A_RLD, 1'b1, 32'd40);
      bus(A_PWM, 1'b1, 32'h0);
      n0 = irq_cnt;
      // odd rows capture on the falling edge of the pulses
      bus(A_CTL, 1'b1, {24'h0, tpcm_pkg::MODE_CAPTURE, 3'h0, ~s[0], 1'b1});
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (14) @(posedge clk_sys);
      bus(A_CT2, 1'b0, 32'h0);
      chk(rd[3], 1);
      bus(A_PWM, 1'b0, 32'h0);
      p1 = rd;
      repeat (10) @(posedge clk_sys);
      bus(A_PWM, 1'b0, 32'h0);
      chk(rd - p1, 14);
      repeat (30) @(posedge clk_sys);
      bus(A_CT2, 1'b0, 32'h0);
      chk(rd[3], 0);
      bus(A_CNT, 1'b0, 32'h0);
      chk(rd > 40, 1);
      chk(irq_cnt - n0, (s == 0 || s == 3) ? 3 : 3 - s);
    end
    stop_test();
  end
endmodule
